// file: acr_map.vh
/*
  Constants for the configuration register block: field positions,
  routing pattern, reset values and probe encodings.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ACR_MAP_VH
`define ACR_MAP_VH

`define ACR_WORD_W 12
`define ACR_DATA_W 10
`define ACR_DEST_HI 11
`define ACR_DEST_LO 10
`define ACR_DEST_REG0 2'b00
`define ACR_DEST_REG1 2'b01
`define ACR_REG0_RESET 12'h020
`define ACR_REG1_RESET 12'h430
`define ACR_BIT_RESET 0
`define ACR_BIT_SYNC 1
`define ACR_BIT_RW 6
`define ACR_BIT_FMT 7
`define ACR_BIT_OFFSET 8
`define ACR_BIT_PROBE_LO 8
`define ACR_BIT_PROBE_HI 9
`define ACR_PROBE_NORMAL 2'b00
`define ACR_PROBE_TOP 2'b01
`define ACR_PROBE_MID 2'b10
`define ACR_PROBE_BOTTOM 2'b11
`define ACR_CAL_IDLE 2'b00
`define ACR_CAL_WAIT 2'b01
`define ACR_CAL_DONE 2'b10

`endif

// file: acr_strobe.v
/*
  Bus strobe decoder: forms internal read and write strobes from the chip
  selects, read and write pins, and yields a one-cycle write pulse.
  Assumes pins are synchronous to ref_clk.
*/
`timescale 1ns/100ps
module acr_strobe (
  input wire ref_clk,
  input wire rst,
  input wire chip_select_low_active_n,
  input wire chip_select_high_active,
  input wire wr_n,
  input wire rd_n,
  input wire rw_combined,
  output wire rd_int,
  output wire wr_pulse
);
  reg wr_int_d_r;
  wire cs_ok;
  wire wr_int;

  assign cs_ok = ~chip_select_low_active_n & chip_select_high_active;
  // Combined pin: high read, low write; read pin ignored
  assign wr_int = rw_combined ? (cs_ok & ~wr_n) : (cs_ok & ~wr_n & rd_n);
  assign rd_int = rw_combined ? (cs_ok & wr_n) : (cs_ok & ~rd_n & wr_n);
  assign wr_pulse = wr_int & ~wr_int_d_r;

  always @(posedge ref_clk)
  begin
    if (rst)
      wr_int_d_r <= 1'b0;
    else
      wr_int_d_r <= wr_int;
  end
endmodule // acr_strobe

// file: acr_config.v
/*
  Configuration registers zero and one of a pipelined converter: write
  decode, soft reset, sync clear, strobe mode, format, probe select and
  offset calibration with stored-offset subtraction.
  Assumes a synchronous host bus and a converter core that hands results
  with a valid pulse.
*/
// Notes on behaviour
// - Probe field picks normal, top, mid, bottom
// - Register one write-only, pattern bits 11:10 = 01
// - Bit 0 set resets both registers
// - Bit 1 set clears sync generator
// - Bit 6 one: combined read/write pin
// - Bit 6 zero: separate read, write pins
// - Bit 7 zero two's complement, one binary
// - Bit 8 set forces zero input, converts once
// - Stored offset subtracted from later results
// - Chip selects and write strobe latch data
`timescale 1ns/100ps
`include "acr_map.vh"
module acr_config (
  input wire ref_clk,
  input wire rst,
  input wire chip_select_low_active_n,
  input wire chip_select_high_active,
  input wire wr_n,
  input wire rd_n,
  input wire [11:0] data_in,
  input wire conv_valid,
  input wire [9:0] conv_data,
  output reg [11:0] adc_config_zero_r,
  output wire rd_int,
  output wire in_reset,
  output reg sync_gen_clear_r,
  output wire rw_combined,
  output wire output_format_select,
  output wire force_zero_input,
  output reg [1:0] probe_select_r,
  output reg offset_busy_r,
  output reg result_valid_r,
  output reg [9:0] result_r
);
  reg [11:0] adc_config_one_r;
  reg [1:0] cal_state_r;
  reg [1:0] cal_state_nxt;
  reg [9:0] offset_r;
  wire wr_pulse;
  wire [1:0] dest;
  wire wr_reg0;
  wire wr_reg1;
  wire [9:0] corrected;
  wire reg1_reset;
  wire reg1_offset;

  acr_strobe u_strobe (
    .ref_clk(ref_clk),
    .rst(rst),
    .chip_select_low_active_n(chip_select_low_active_n),
    .chip_select_high_active(chip_select_high_active),
    .wr_n(wr_n),
    .rd_n(rd_n),
    .rw_combined(rw_combined),
    .rd_int(rd_int),
    .wr_pulse(wr_pulse)
  );

  assign dest = data_in[`ACR_DEST_HI:`ACR_DEST_LO];
  assign wr_reg0 = wr_pulse & (dest == `ACR_DEST_REG0);
  assign wr_reg1 = wr_pulse & (dest == `ACR_DEST_REG1);
  assign reg1_reset = data_in[`ACR_BIT_RESET];
  assign reg1_offset = data_in[`ACR_BIT_OFFSET];

  assign in_reset = adc_config_one_r[`ACR_BIT_RESET];
  assign rw_combined = adc_config_one_r[`ACR_BIT_RW];
  assign output_format_select = adc_config_one_r[`ACR_BIT_FMT];
  assign force_zero_input = offset_busy_r;

  // Register one, write only, never driven onto the read path
  always @(posedge ref_clk)
  begin
    if (rst)
      adc_config_one_r <= `ACR_REG1_RESET;
    else if (wr_reg1 && reg1_reset)
      adc_config_one_r <= `ACR_REG1_RESET | 12'h001;
    else if (wr_reg1)
      adc_config_one_r <= data_in;
  end

  // Register zero held at default while in reset
  always @(posedge ref_clk)
  begin
    if (rst)
      adc_config_zero_r <= `ACR_REG0_RESET;
    else if ((wr_reg1 && reg1_reset) || (in_reset && !wr_reg1))
      adc_config_zero_r <= `ACR_REG0_RESET;
    else if (wr_reg0)
      adc_config_zero_r <= data_in;
  end

  // Probe select decoded from register zero
  always @(posedge ref_clk)
  begin
    if (rst)
      probe_select_r <= `ACR_PROBE_NORMAL;
    else
      probe_select_r <= adc_config_zero_r[`ACR_BIT_PROBE_HI:`ACR_BIT_PROBE_LO];
  end

  // One-cycle sync generator clear
  always @(posedge ref_clk)
  begin
    if (rst)
      sync_gen_clear_r <= 1'b0;
    else
      sync_gen_clear_r <= wr_reg1 & data_in[`ACR_BIT_SYNC];
  end

  // Offset calibration sequence
  always @*
  begin
    cal_state_nxt = cal_state_r;
    case (cal_state_r)
      `ACR_CAL_IDLE:
      begin
        if (wr_reg1 && reg1_offset && !reg1_reset)
          cal_state_nxt = `ACR_CAL_WAIT;
      end
      `ACR_CAL_WAIT:
      begin
        if (in_reset)
          cal_state_nxt = `ACR_CAL_IDLE;
        else if (conv_valid)
          cal_state_nxt = `ACR_CAL_DONE;
      end
      `ACR_CAL_DONE:
      begin
        if (wr_reg1 && reg1_offset && !reg1_reset)
          cal_state_nxt = `ACR_CAL_WAIT;
        else if (in_reset)
          cal_state_nxt = `ACR_CAL_IDLE;
      end
      default:
        cal_state_nxt = `ACR_CAL_IDLE;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      cal_state_r <= `ACR_CAL_IDLE;
      offset_busy_r <= 1'b0;
      offset_r <= 10'h000;
    end
    else
    begin
      cal_state_r <= cal_state_nxt;
      offset_busy_r <= (cal_state_nxt == `ACR_CAL_WAIT);
      if (in_reset)
        offset_r <= 10'h000;
      else if (cal_state_r == `ACR_CAL_WAIT && conv_valid)
        offset_r <= conv_data;
    end
  end

  // Offset removal and output format
  assign corrected = conv_data - offset_r;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      result_valid_r <= 1'b0;
      result_r <= 10'h000;
    end
    else
    begin
      result_valid_r <= conv_valid & (cal_state_r != `ACR_CAL_WAIT) & ~in_reset;
      if (conv_valid && cal_state_r != `ACR_CAL_WAIT)
        result_r <= output_format_select ? corrected
          : {~corrected[9], corrected[8:0]};
    end
  end
endmodule // acr_config

// file: acr_core_model.sv
/* Converter core stand-in: one valid pulse per request.
   Assumes requests at least two cycles apart. */
`timescale 1ns/100ps
module acr_core_model (
  input wire ref_clk,
  input wire fire,
  input wire [9:0] val,
  output reg conv_valid,
  output reg [9:0] conv_data
);
  initial conv_data = 10'h155;
  always @(posedge ref_clk)
  begin
    conv_valid <= fire;
    conv_data <= fire ? val : ~conv_data;
  end
endmodule // acr_core_model

// file: acr_asserts.sv
/* Port checker for acr_config.
   Assumes bind to every acr_config instance. */
`timescale 1ns/100ps
module acr_asserts (
  input wire ref_clk,
  input wire rst,
  input wire chip_select_low_active_n,
  input wire chip_select_high_active,
  input wire wr_n,
  input wire rd_n,
  input wire [11:0] data_in,
  input wire conv_valid,
  input wire [11:0] adc_config_zero_r,
  input wire in_reset,
  input wire sync_gen_clear_r,
  input wire output_format_select,
  input wire rw_combined,
  input wire offset_busy_r
);
  wire st = !chip_select_low_active_n & chip_select_high_active & !wr_n & (rw_combined | rd_n);
  reg st_r;
  wire tk = st & !st_r;
  wire t1 = tk & (data_in[11:10] == 2'b01);
  always @(posedge ref_clk)
    st_r <= st;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_hold: assert property (in_reset |-> adc_config_zero_r == 12'h020)
    else $error("reg0 not default");
  a_soft_reset: assert property (t1 && data_in[0] |-> ##2 in_reset && !output_format_select)
    else $error("soft reset missed");
  a_format_load: assert property (t1 && !data_in[0]
    |-> ##2 output_format_select == $past(data_in[7], 2)) else $error("format wrong");
  a_reg0_write: assert property (tk && data_in[11:10] == 2'b00 && !in_reset
    |-> ##2 adc_config_zero_r == $past(data_in, 2)) else $error("reg0 load");
  a_route_skip: assert property (tk && data_in[11]
    |-> ##1 $stable(adc_config_zero_r) && $stable(output_format_select)) else $error("route");
  a_sync_pulse: assert property (t1 && data_in[1] |-> ##[1:3] sync_gen_clear_r)
    else $error("sync clear missed");
  a_cal_start: assert property (t1 && data_in[8] && !data_in[0] |-> ##[1:4] offset_busy_r)
    else $error("cal start");
  a_cal_store: assert property (offset_busy_r && conv_valid |=> !offset_busy_r)
    else $error("cal end");
endmodule // acr_asserts
bind acr_config acr_asserts u_chk (.*);

// file: adc_config_reg_one_and_test_select_test.sv
/* Register write bench for acr_config.
   Assumes acr_core_model and acr_asserts. */
`timescale 1ns/100ps
module adc_config_reg_one_and_test_select_test;
  logic ref_clk, rst, chip_select_low_active_n, chip_select_high_active, wr_n, rd_n, fire;
  logic conv_valid, rd_int, in_reset, sync_gen_clear_r, rw_combined, output_format_select;
  logic force_zero_input, offset_busy_r, result_valid_r;
  logic [11:0] data_in, adc_config_zero_r;
  logic [9:0] conv_data, result_r, val, last_res;
  logic [1:0] probe_select_r;
  integer n_mismatch, comparisons, i;
  acr_config uut (.*);
  acr_core_model core (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (result_valid_r === 1'b1) last_res <= result_r;
  task chk(input string nm, input [11:0] seen, input [11:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) n_mismatch = n_mismatch + 1;
    if (seen !== exp) $display("Error %s expected %h seen %h", nm, exp, seen);
  endtask
  task drv(input a, input r, input [11:0] d);
    chip_select_low_active_n <= !a;
    chip_select_high_active <= a;
    wr_n <= !a;
    rd_n <= !r;
    data_in <= d;
  endtask
  task wr(input [11:0] w, input r);
    @(posedge ref_clk) drv(1'b1, r, w);
    repeat (2) @(posedge ref_clk);
    drv(1'b0, 1'b0, ~w);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task cv(input [9:0] v);
    @(posedge ref_clk) fire <= 1'b1;
    val <= v;
    @(posedge ref_clk) fire <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task end_of_test;
    $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
  initial
  begin
    n_mismatch = 0;
    comparisons = 0;
    rst = 1'b1;
    fire = 1'b0;
    val = 10'h000;
    drv(1'b0, 1'b0, 12'h000);
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      wr({2'b00, i[1:0], 8'h20}, 1'b0);
      chk("probe", {10'h000, probe_select_r}, {10'h000, i[1:0]});
    end
    wr(12'h820, 1'b0);
    chk("route", adc_config_zero_r, 12'h320);
    wr(12'h480, 1'b0);
    cv(10'h123);
    chk("bin", {2'b00, last_res}, 12'h123);
    wr(12'h400, 1'b0);
    cv(10'h123);
    chk("twos", {2'b00, last_res}, 12'h323);
    wr(12'h500, 1'b0);
    chk("busy", {11'h000, force_zero_input}, 12'h001);
    cv(10'h005);
    cv(10'h105);
    chk("offs", {2'b00, last_res}, 12'h300);
    wr(12'h440, 1'b0);
    wr(12'h100, 1'b1);
    chk("comb", {10'h000, probe_select_r}, 12'h001);
    wr(12'h402, 1'b0);
    wr(12'h200, 1'b1);
    chk("sep", {10'h000, probe_select_r}, 12'h001);
    wr(12'h401, 1'b0);
    wr(12'h300, 1'b0);
    chk("held", adc_config_zero_r, 12'h020);
    wr(12'h400, 1'b0);
    chk("out", {11'h000, in_reset}, 12'h000);
    @(posedge ref_clk);
    chip_select_low_active_n <= 1'b0;
    chip_select_high_active <= 1'b1;
    rd_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("rdint", {11'h000, rd_int}, 12'h001);
    @(posedge ref_clk) drv(1'b0, 1'b0, 12'h000);
    @(posedge ref_clk);
    #1;
    chk("rdoff", {11'h000, rd_int}, 12'h000);
    end_of_test;
  end
endmodule // adc_config_reg_one_and_test_select_test
